//--- hdl/dln_byte_buf.sv
// Small FIFO between the byte sequencer and the link controller.
// Assumes both sides run on clk_i; DEPTH of at least two.
module dln_byte_buf
	import dln_pkg::*;
#(
	parameter int unsigned WIDTH = 11,
	parameter int unsigned DEPTH = 2
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);

	localparam int unsigned AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	// Pointer step with wrap at DEPTH
	function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
		if (p == (AW)'(DEPTH - 1)) begin
			return '0;
		end
		return p + 1'b1;
	endfunction : step

	////////////////////////////////////////////////////////////////////////
	// Handshakes: full and empty come straight from the count
	assign in_ready_o  = (count_reg != FULL_CNT);
	assign out_valid_o = (count_reg != '0);
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	assign out_data_o  = mem[rd_ptr_reg];

	// Storage
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data_i;
		end
	end

	// Pointers and fill count
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= step(wr_ptr_reg);
			end
			if (pop) begin
				rd_ptr_reg <= step(rd_ptr_reg);
			end
			if (push && !pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end

endmodule : dln_byte_buf

//--- hdl/dln_node.sv
// Digital input link node: samples sensors, packs input and diagnosis
// bytes per link cycle, holds the parameter byte and drives the lamps.
// Assumes a link controller on clk_i that frames the bytes on the wire,
// and non-volatile storage that offers the stored parameter at boot.
module dln_node
	import dln_pkg::*;
#(
	parameter int unsigned COMM_TIMEOUT = COMM_TIMEOUT_CYC,
	parameter int unsigned FLASH_HALF   = FLASH_HALF_CYC,
	parameter int unsigned BUF_DEPTH    = 2
) (
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	input  wire logic [CS_W-1:0]   coding_switch_i,
	input  wire logic [ADDR_W-1:0] address_switch_i,
	input  wire logic [7:0]        sensor_pin4_i,
	input  wire logic [7:0]        sensor_pin2_i,
	input  wire logic              elec_uv_i,
	input  wire logic              elec_ov_i,
	input  wire logic              sens_present_i,
	input  wire logic              sens_uv_i,
	input  wire logic              sens_ov_i,
	input  wire logic              sens_overload_i,
	input  wire logic [7:0]        param_boot_i,
	input  wire logic              link_cycle_i,
	input  wire logic              param_valid_i,
	input  wire logic [7:0]        param_data_i,
	output logic                   tx_valid_o,
	input  wire logic              tx_ready_i,
	output dln_link_byte_t         tx_byte_o,
	output logic                   cfg_valid_o,
	output logic                   baud_high_o,
	output logic                   baud_tick_o,
	output logic                   two_byte_o,
	output logic [ADDR_W-1:0]      link_addr_o,
	output logic                   auto_addr_o,
	output logic [7:0]             param_hold_o,
	output logic [7:0]             param_eff_o,
	output logic [15:0]            input_image_o,
	output logic [7:0]             diag_byte_o,
	output logic [15:0]            chan_lamp_o,
	output logic                   comm_lamp_o,
	output logic                   supply_lamp_o,
	output logic                   sens_supply_en_o
);

	localparam int unsigned SYNC_W = CS_W + ADDR_W + 16 + 6;
	localparam int unsigned TO_W   = $clog2(COMM_TIMEOUT + 1);
	localparam int unsigned FL_W   = $clog2(FLASH_HALF + 1);
	localparam logic [TO_W-1:0] TO_LAST = TO_W'(COMM_TIMEOUT - 1);
	localparam logic [FL_W-1:0] FL_LAST = FL_W'(FLASH_HALF - 1);
	localparam logic [BAUD_CNT_W-1:0] DIV_HIGH_LAST =
		BAUD_CNT_W'(BAUD_DIV_HIGH - 1);
	localparam logic [BAUD_CNT_W-1:0] DIV_LOW_LAST =
		BAUD_CNT_W'(BAUD_DIV_LOW - 1);

	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [SYNC_W-1:0]     sync1_reg;
	logic [SYNC_W-1:0]     sync2_reg;
	logic [SYNC_W-1:0]     async_in;
	logic [CS_W-1:0]       cs_s;
	logic [ADDR_W-1:0]     addr_s;
	logic [7:0]            pin4_s;
	logic [7:0]            pin2_s;
	logic                  elec_uv_s;
	logic                  elec_ov_s;
	logic                  sens_present_s;
	logic                  sens_uv_s;
	logic                  sens_ov_s;
	logic                  sens_overload_s;
	logic [1:0]            cfg_wait_reg;
	logic                  cfg_done_reg;
	logic                  baud_high_reg;
	logic                  two_byte_reg;
	logic [ADDR_W-1:0]     addr_reg;
	logic [7:0]            param_hold_reg;
	logic [7:0]            param_eff_reg;
	logic                  ovl_latch_reg;
	logic                  ovl_state;
	logic [BAUD_CNT_W-1:0] baud_cnt_reg;
	logic                  baud_tick_reg;
	logic [TO_W-1:0]       comm_cnt_reg;
	logic                  comm_lost_reg;
	logic [FL_W-1:0]       flash_cnt_reg;
	logic                  flash_reg;
	logic [15:0]           image_reg;
	logic [7:0]            diag_reg;
	logic [15:0]           lamp_reg;
	logic                  supply_lamp_reg;
	logic [15:0]           snap_image_reg;
	logic [7:0]            snap_diag_reg;
	dln_seq_t              seq_reg;
	dln_link_byte_t        push_byte;
	logic                  push_valid;
	logic                  push_ready;
	logic [7:0]            diag_next;

	// Out-of-window test shared by both supplies
	function automatic logic out_of_range(input logic uv, input logic ov);
		return uv || ov;
	endfunction : out_of_range

	////////////////////////////////////////////////////////////////////////
	// Two-flop synchroniser for every pin input
	assign async_in = {coding_switch_i, address_switch_i, sensor_pin2_i,
		sensor_pin4_i, elec_uv_i, elec_ov_i, sens_present_i, sens_uv_i,
		sens_ov_i, sens_overload_i};

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= async_in;
			sync2_reg <= sync1_reg;
		end
	end

	assign {cs_s, addr_s, pin2_s, pin4_s, elec_uv_s, elec_ov_s,
		sens_present_s, sens_uv_s, sens_ov_s, sens_overload_s} = sync2_reg;

	////////////////////////////////////////////////////////////////////////
	// One-shot capture of switches and boot parameter after reset release
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg_wait_reg  <= '0;
			cfg_done_reg  <= 1'b0;
			baud_high_reg <= 1'b1;
			two_byte_reg  <= 1'b1;
			addr_reg      <= ADDR_AUTO;
			param_eff_reg <= PARAM_RESET;
		end else if (!cfg_done_reg) begin
			if (cfg_wait_reg == CFG_WAIT_CYC) begin
				cfg_done_reg  <= 1'b1;
				baud_high_reg <= cs_s[CS_BAUD_BIT];
				two_byte_reg  <= cs_s[CS_LEN_BIT];
				addr_reg      <= addr_s;
				param_eff_reg <= param_boot_i;
			end else begin
				cfg_wait_reg <= cfg_wait_reg + 1'b1;
			end
		end
	end

	// Received parameter byte is held for storage, not applied here
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			param_hold_reg <= PARAM_RESET;
		end else if (param_valid_i) begin
			param_hold_reg <= param_data_i;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bit-rate enable pulse from the selected divider
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			baud_cnt_reg  <= '0;
			baud_tick_reg <= 1'b0;
		end else if (baud_cnt_reg == (baud_high_reg ? DIV_HIGH_LAST
			: DIV_LOW_LAST)) begin
			baud_cnt_reg  <= '0;
			baud_tick_reg <= 1'b1;
		end else begin
			baud_cnt_reg  <= baud_cnt_reg + 1'b1;
			baud_tick_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Link watchdog: lost until first cycle, and after a long silence
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			comm_cnt_reg  <= '0;
			comm_lost_reg <= 1'b1;
		end else if (link_cycle_i && cfg_done_reg) begin
			comm_cnt_reg  <= '0;
			comm_lost_reg <= 1'b0;
		end else if (comm_cnt_reg == TO_LAST) begin
			comm_lost_reg <= 1'b1;
		end else begin
			comm_cnt_reg <= comm_cnt_reg + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sensor supply overload: latched or self-recovering by parameter
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ovl_latch_reg <= 1'b0;
		end else if (sens_overload_s && param_eff_reg[PAR_LATCH_BIT]) begin
			ovl_latch_reg <= 1'b1;
		end
	end

	assign ovl_state = sens_overload_s || ovl_latch_reg;

	////////////////////////////////////////////////////////////////////////
	// Flash timebase for the supply lamp
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flash_cnt_reg <= '0;
			flash_reg     <= 1'b0;
		end else if (flash_cnt_reg == FL_LAST) begin
			flash_cnt_reg <= '0;
			flash_reg     <= !flash_reg;
		end else begin
			flash_cnt_reg <= flash_cnt_reg + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Diagnosis byte, reserved bits zero
	always_comb begin
		diag_next              = BYTE_ZERO;
		diag_next[DG_ELEC_BIT] = out_of_range(elec_uv_s,
			elec_ov_s);
		diag_next[DG_SENS_BIT] = out_of_range(sens_uv_s, sens_ov_s)
			|| ovl_state;
		diag_next[DG_COMM_BIT] = comm_lost_reg;
	end

	// Input image, diagnosis and lamps
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			image_reg       <= IMAGE_RESET;
			diag_reg        <= BYTE_ZERO;
			lamp_reg        <= IMAGE_RESET;
			supply_lamp_reg <= 1'b0;
		end else begin
			image_reg <= {pin2_s, pin4_s};
			diag_reg  <= diag_next;
			lamp_reg  <= {pin2_s & {CHAN_PER_BYTE{two_byte_reg}},
				pin4_s};
			if (!sens_present_s) begin
				supply_lamp_reg <= 1'b0;
			end else if (out_of_range(sens_uv_s, sens_ov_s) || ovl_state)
			begin
				supply_lamp_reg <= flash_reg;
			end else begin
				supply_lamp_reg <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Byte sequencer: snapshot at cycle start, then input and diagnosis
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			seq_reg        <= DLN_SEQ_IDLE;
			snap_image_reg <= IMAGE_RESET;
			snap_diag_reg  <= BYTE_ZERO;
		end else begin
			case (seq_reg)
				DLN_SEQ_IDLE: begin
					if (link_cycle_i && cfg_done_reg) begin
						snap_image_reg <= image_reg;
						snap_diag_reg  <= diag_next;
						seq_reg        <= DLN_SEQ_B0;
					end
				end
				DLN_SEQ_B0: begin
					if (push_ready) begin
						seq_reg <= two_byte_reg ? DLN_SEQ_B1
							: DLN_SEQ_DIAG;
					end
				end
				DLN_SEQ_B1: begin
					if (push_ready) begin
						seq_reg <= DLN_SEQ_DIAG;
					end
				end
				DLN_SEQ_DIAG: begin
					if (push_ready) begin
						seq_reg <= DLN_SEQ_IDLE;
					end
				end
				default: begin
					seq_reg <= DLN_SEQ_IDLE;
				end
			endcase
		end
	end

	// Byte offered to the buffer in B0, B1 and DIAG; nothing offered in IDLE
	always_comb begin
		push_valid     = 1'b1;
		push_byte.last = 1'b0;
		push_byte.kind = DLN_KIND_IN0;
		push_byte.data = snap_image_reg[7:0];
		case (seq_reg)
			DLN_SEQ_B0: begin
				push_byte.data = snap_image_reg[7:0];
			end
			DLN_SEQ_B1: begin
				push_byte.kind = DLN_KIND_IN1;
				push_byte.data = snap_image_reg[15:8];
			end
			DLN_SEQ_DIAG: begin
				push_byte.last = 1'b1;
				push_byte.kind = DLN_KIND_DIAG;
				push_byte.data = snap_diag_reg;
			end
			default: begin
				push_valid = 1'b0;
			end
		endcase
	end

	// Two-entry buffer so a stalled link controller loses no byte
	dln_byte_buf #(
		.WIDTH ($bits(dln_link_byte_t)),
		.DEPTH (BUF_DEPTH)
	) u_buf (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n_i),
		.in_valid_i  (push_valid),
		.in_ready_o  (push_ready),
		.in_data_i   (push_byte),
		.out_valid_o (tx_valid_o),
		.out_ready_i (tx_ready_i),
		.out_data_o  (tx_byte_o)
	);

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign cfg_valid_o      = cfg_done_reg;
	assign baud_high_o      = baud_high_reg;
	assign baud_tick_o      = baud_tick_reg;
	assign two_byte_o       = two_byte_reg;
	assign link_addr_o      = addr_reg;
	assign auto_addr_o      = (addr_reg == ADDR_AUTO);
	assign param_hold_o     = param_hold_reg;
	assign param_eff_o      = param_eff_reg;
	assign input_image_o    = image_reg;
	assign diag_byte_o      = diag_reg;
	assign chan_lamp_o      = lamp_reg;
	assign comm_lamp_o      = comm_lost_reg;
	assign supply_lamp_o    = supply_lamp_reg;
	assign sens_supply_en_o = !ovl_state;

endmodule : dln_node

//--- hdl/dln_pkg.sv
// Shared constants and types of the digital input link node.
// Assumes one 125 MHz clock and a link controller on that same clock.
package dln_pkg;

	////////////////////////////////////////////////////////////////////////
	// Clock and timing
	localparam int unsigned CLK_HZ          = 125_000_000;
	localparam int unsigned BAUD_LOW_HZ     = 125_000;
	localparam int unsigned BAUD_HIGH_HZ    = 250_000;
	localparam int unsigned BAUD_DIV_LOW    = CLK_HZ / BAUD_LOW_HZ;
	localparam int unsigned BAUD_DIV_HIGH   = CLK_HZ / BAUD_HIGH_HZ;
	localparam int unsigned BAUD_CNT_W      = 10;
	// Longest silence before the link counts as interrupted
	localparam int unsigned COMM_TIMEOUT_MS = 10;
	localparam int unsigned COMM_TIMEOUT_CYC =
		(CLK_HZ / 1000) * COMM_TIMEOUT_MS;
	// Half period of the flashing supply lamp
	localparam int unsigned FLASH_HALF_MS   = 250;
	localparam int unsigned FLASH_HALF_CYC  =
		(CLK_HZ / 1000) * FLASH_HALF_MS;
	// Cycles after reset release before the switches are captured
	localparam logic [1:0]  CFG_WAIT_CYC    = 2'h3;

	////////////////////////////////////////////////////////////////////////
	// Coding switch layout (switch bit 1 sits at index 0)
	localparam int unsigned CS_BAUD_BIT     = 0;
	localparam int unsigned CS_LEN_BIT      = 2;
	localparam int unsigned CS_W            = 4;
	localparam int unsigned ADDR_W          = 4;
	localparam logic [ADDR_W-1:0] ADDR_AUTO = 4'h0;

	////////////////////////////////////////////////////////////////////////
	// Diagnosis and parameter byte layout
	localparam int unsigned DG_ELEC_BIT     = 0;
	localparam int unsigned DG_SENS_BIT     = 1;
	localparam int unsigned DG_COMM_BIT     = 7;
	localparam int unsigned PAR_LATCH_BIT   = 0;
	localparam logic [7:0]  BYTE_ZERO       = 8'h00;
	localparam logic [7:0]  PARAM_RESET     = 8'h00;
	localparam logic [15:0] IMAGE_RESET     = 16'h0000;
	localparam int unsigned CHAN_PER_BYTE   = 8;

	////////////////////////////////////////////////////////////////////////
	// Bytes handed to the link controller
	typedef enum logic [1:0] {
		DLN_KIND_IN0  = 2'b00,
		DLN_KIND_IN1  = 2'b01,
		DLN_KIND_DIAG = 2'b10
	} dln_kind_t;

	typedef struct packed {
		logic       last;
		dln_kind_t  kind;
		logic [7:0] data;
	} dln_link_byte_t;

	// Sequencer states of one link cycle
	typedef enum logic [1:0] {
		DLN_SEQ_IDLE = 2'b00,
		DLN_SEQ_B0   = 2'b01,
		DLN_SEQ_B1   = 2'b10,
		DLN_SEQ_DIAG = 2'b11
	} dln_seq_t;

endpackage : dln_pkg

//--- sim/digital_input_link_node_test.sv
// Self-checking bench of the link node with a link master model.
// Assumes package, node, buffer, checker and master compiled first.
module digital_input_link_node_test;
	timeunit 1ns;
	timeprecision 1ps;
	import dln_pkg::*;
	localparam int unsigned CT = 50;
	localparam int unsigned FH = 8;
	logic clk_i = 1'h0, rst_n_i = 1'h0, en = 1'h0, slow = 1'h0, ovl;
	logic [3:0] coding_switch_i = 4'h0, address_switch_i = 4'h0;
	logic [7:0] sensor_pin4_i = 8'h00, sensor_pin2_i = 8'h00;
	logic elec_uv_i = 1'h0, elec_ov_i = 1'h0, sens_present_i = 1'h1;
	logic sens_uv_i = 1'h0, sens_ov_i = 1'h0, sens_overload_i = 1'h0;
	logic param_valid_i = 1'h0;
	logic [7:0] param_boot_i = 8'h00, param_data_i = 8'h00;
	logic link_cycle_i, tx_ready_i, tx_valid_o, cfg_valid_o, baud_high_o;
	logic baud_tick_o, two_byte_o, auto_addr_o, comm_lamp_o, supply_lamp_o;
	logic sens_supply_en_o, got;
	logic [3:0] link_addr_o;
	logic [7:0] param_hold_o, param_eff_o, diag_byte_o;
	logic [15:0] input_image_o, chan_lamp_o;
	dln_link_byte_t tx_byte_o, got_byte;
	int n_errors = 0, compares = 0;

	dln_node #(.COMM_TIMEOUT(CT), .FLASH_HALF(FH), .BUF_DEPTH(2)) DUT (
		.clk_i, .rst_n_i, .coding_switch_i, .address_switch_i,
		.sensor_pin4_i, .sensor_pin2_i, .elec_uv_i, .elec_ov_i,
		.sens_present_i, .sens_uv_i, .sens_ov_i, .sens_overload_i,
		.param_boot_i, .link_cycle_i, .param_valid_i, .param_data_i,
		.tx_valid_o, .tx_ready_i, .tx_byte_o, .cfg_valid_o, .baud_high_o,
		.baud_tick_o, .two_byte_o, .link_addr_o, .auto_addr_o,
		.param_hold_o, .param_eff_o, .input_image_o, .diag_byte_o,
		.chan_lamp_o, .comm_lamp_o, .supply_lamp_o, .sens_supply_en_o);
	dln_link_master #(.PERIOD(16)) master (.clk_i, .en_i(en),
		.slow_i(slow), .tx_valid_i(tx_valid_o), .tx_byte_i(tx_byte_o),
		.link_cycle_o(link_cycle_i), .tx_ready_o(tx_ready_i),
		.got_o(got), .got_byte_o(got_byte));

	initial forever #4 clk_i = ~clk_i;

	//////////////////////////////////////////////////////////////
	// Checking and closing
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
		input string what);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: %s", $time, what);
		end
	endtask : chk
	task automatic give_verdict();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict
	task automatic bad(input string what);
		n_errors++;
		$display("unexpected at %0t: %s timed out", $time, what);
		give_verdict();
	endtask : bad

	//////////////////////////////////////////////////////////////
	// Model of the diagnosis byte and helpers
	function automatic logic [7:0] exp_diag(input logic lost);
		return {lost, 5'h00, sens_uv_i | sens_ov_i | ovl,
			elec_uv_i | elec_ov_i};
	endfunction : exp_diag
	task automatic settle();
		repeat (4) @(negedge clk_i);
	endtask : settle
	task automatic do_reset();
		@(negedge clk_i);
		rst_n_i = 1'h0;
		repeat (8) @(negedge clk_i);
		chk({tx_valid_o, cfg_valid_o, comm_lamp_o}, 16'h0001, "reset");
		rst_n_i = 1'h1;
		for (int i = 0; cfg_valid_o !== 1'h1; i++) begin
			if (i > 20) bad("config");
			@(negedge clk_i);
		end
	endtask : do_reset
	task automatic wait_tick(output int n);
		n = 1;
		@(negedge clk_i);
		while (baud_tick_o !== 1'h1) begin
			if (++n > 1100) bad("tick");
			@(negedge clk_i);
		end
	endtask : wait_tick
	// Whole link cycles after the first end-of-cycle byte seen
	task automatic stream(input logic two);
		logic [10:0] q[$];
		int t, sy;
		t = 0;
		sy = 0;
		repeat (3) begin
			q.push_back({1'h0, DLN_KIND_IN0, sensor_pin4_i});
			if (two)
				q.push_back({1'h0, DLN_KIND_IN1, sensor_pin2_i});
			q.push_back({1'h1, DLN_KIND_DIAG, exp_diag(1'h0)});
		end
		en = 1'h1;
		while (q.size() > 0) begin
			if (++t > 600) bad("stream");
			@(negedge clk_i);
			if (got && sy)
				chk(got_byte, q.pop_front(), "link byte");
			if (got && got_byte.last)
				sy = 1;
		end
	endtask : stream

	//////////////////////////////////////////////////////////////
	// Main sequence: one pass per baud and length setting
	initial begin
		logic [3:0] cs, as;
		logic [7:0] boot;
		int gap;
		logic hi, lo;
		void'($urandom(32'hd74c));
		for (int m = 0; m < 4; m++) begin
			cs = 4'($urandom);
			cs[0] = m[0];
			cs[2] = m[1];
			as = (m == 0) ? 4'h0 : 4'($urandom);
			boot = 8'($urandom);
			boot[0] = m[0];
			coding_switch_i = cs;
			address_switch_i = as;
			param_boot_i = boot;
			ovl = 1'h0;
			do_reset();
			chk(baud_high_o, cs[0], "baud");
			chk(two_byte_o, cs[2], "length");
			chk({auto_addr_o, link_addr_o}, {as == 4'h0, as}, "addr");
			coding_switch_i = ~cs;
			address_switch_i = ~as;
			param_boot_i = ~boot;
			settle();
			chk({baud_high_o, two_byte_o, link_addr_o},
				{cs[0], cs[2], as}, "switch moved");
			wait_tick(gap);
			wait_tick(gap);
			chk(16'(gap), m[0] ? 16'h01f4 : 16'h03e8, "tick");
			sensor_pin4_i = 8'($urandom);
			sensor_pin2_i = 8'($urandom);
			elec_uv_i = 1'($urandom);
			elec_ov_i = 1'($urandom);
			settle();
			chk(supply_lamp_o, 1'h1, "steady");
			chk(input_image_o, {sensor_pin2_i, sensor_pin4_i}, "image");
			chk(chan_lamp_o, {sensor_pin2_i & {8{cs[2]}}, sensor_pin4_i},
				"lamps");
			chk(diag_byte_o, exp_diag(1'h1), "diag");
			slow = m[1];
			stream(cs[2]);
			chk(comm_lamp_o, 1'h0, "link lamp");
			param_valid_i = 1'h1;
			param_data_i = 8'($urandom);
			@(negedge clk_i);
			param_data_i = ~param_data_i;
			@(negedge clk_i);
			param_valid_i = 1'h0;
			chk(param_hold_o, param_data_i, "param");
			chk(param_eff_o, boot, "boot param");
			en = 1'h0;
			repeat (CT + 40) @(negedge clk_i);
			chk({comm_lamp_o, diag_byte_o}, {1'h1, exp_diag(1'h1)}, "lost");
			sens_uv_i = ~m[1];
			sens_ov_i = m[1];
			hi = 1'h0;
			lo = 1'h0;
			repeat (4 * FH) begin
				@(negedge clk_i);
				hi |= supply_lamp_o === 1'h1;
				lo |= supply_lamp_o === 1'h0;
			end
			chk({hi, lo, diag_byte_o[1]}, 3'h7, "flash");
			sens_present_i = 1'h0;
			settle();
			chk(supply_lamp_o, 1'h0, "absent");
			sens_present_i = 1'h1;
			sens_uv_i = 1'h0;
			sens_ov_i = 1'h0;
			sens_overload_i = 1'h1;
			settle();
			chk(sens_supply_en_o, 1'h0, "overload");
			sens_overload_i = 1'h0;
			ovl = m[0];
			settle();
			chk({sens_supply_en_o, diag_byte_o}, {~m[0], exp_diag(1'h1)},
				"overload latch");
		end
		give_verdict();
	end
endmodule : digital_input_link_node_test

bind dln_node dln_node_chk #(.COMM_TIMEOUT(COMM_TIMEOUT)) chk_i (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .elec_uv_i(elec_uv_i),
	.elec_ov_i(elec_ov_i), .sens_uv_i(sens_uv_i), .sens_ov_i(sens_ov_i),
	.sens_overload_i(sens_overload_i), .link_cycle_i(link_cycle_i),
	.tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
	.tx_byte_o(tx_byte_o), .cfg_valid_o(cfg_valid_o),
	.two_byte_o(two_byte_o), .link_addr_o(link_addr_o),
	.auto_addr_o(auto_addr_o), .input_image_o(input_image_o),
	.diag_byte_o(diag_byte_o), .chan_lamp_o(chan_lamp_o),
	.comm_lamp_o(comm_lamp_o), .sens_supply_en_o(sens_supply_en_o));

//--- sim/dln_link_master.sv
// Link master model: reference cycle pulses and a byte sink.
// Assumes the node on the same clock; ready may stall at random.
module dln_link_master
	import dln_pkg::*;
#(
	parameter int unsigned PERIOD = 16
) (
	input  wire logic           clk_i,
	input  wire logic           en_i,
	input  wire logic           slow_i,
	input  wire logic           tx_valid_i,
	input  wire dln_link_byte_t tx_byte_i,
	output logic                link_cycle_o,
	output logic                tx_ready_o,
	output logic                got_o,
	output dln_link_byte_t      got_byte_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned cnt = 0;

	initial begin
		link_cycle_o = 1'h0;
		tx_ready_o = 1'h1;
		got_o = 1'h0;
	end

	// One-cycle reference pulse per period; ready stalls when slow
	always @(negedge clk_i) begin
		cnt <= (cnt + 1) % PERIOD;
		link_cycle_o <= en_i && cnt == 0;
		tx_ready_o <= slow_i ? 1'($urandom % 3 == 0) : 1'h1;
	end

	// Take a byte at each edge where valid meets ready
	always @(posedge clk_i) begin
		got_o <= tx_valid_i && tx_ready_o;
		got_byte_o <= tx_byte_i;
	end
endmodule : dln_link_master

//--- sim/dln_node_chk.sv
// Port assertions of the link node.
// Assumes a bind onto dln_node that hands on COMM_TIMEOUT.
module dln_node_chk
	import dln_pkg::*;
#(
	parameter int unsigned COMM_TIMEOUT = 50
) (
	input wire logic              clk_i,
	input wire logic              rst_n_i,
	input wire logic              elec_uv_i,
	input wire logic              elec_ov_i,
	input wire logic              sens_uv_i,
	input wire logic              sens_ov_i,
	input wire logic              sens_overload_i,
	input wire logic              link_cycle_i,
	input wire logic              tx_valid_o,
	input wire logic              tx_ready_i,
	input wire dln_link_byte_t    tx_byte_o,
	input wire logic              cfg_valid_o,
	input wire logic              two_byte_o,
	input wire logic [ADDR_W-1:0] link_addr_o,
	input wire logic              auto_addr_o,
	input wire logic [15:0]       input_image_o,
	input wire logic [7:0]        diag_byte_o,
	input wire logic [15:0]       chan_lamp_o,
	input wire logic              comm_lamp_o,
	input wire logic              sens_supply_en_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned quiet_reg;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	//////////////////////////////////////////////////////////////
	// Cycles since the last taken reference cycle, saturating
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			quiet_reg <= 0;
		else if (link_cycle_i && cfg_valid_o)
			quiet_reg <= 0;
		else if (quiet_reg < COMM_TIMEOUT + 8)
			quiet_reg <= quiet_reg + 1;
	end

	//////////////////////////////////////////////////////////////
	// Configuration, diagnosis, lamps and stream
	AST_CFG_KEEP: assert property (cfg_valid_o |=> cfg_valid_o)
		else $error("config capture dropped");
	AST_CFG_HOLD: assert property (cfg_valid_o && $past(cfg_valid_o) |->
		$stable(two_byte_o) && $stable(link_addr_o))
		else $error("switch setting changed while running");
	AST_AUTO: assert property (auto_addr_o == (link_addr_o == ADDR_AUTO))
		else $error("automatic address flag wrong");
	AST_RSV: assert property (diag_byte_o[6:2] == 5'h00)
		else $error("reserved diagnosis bits set");
	AST_ELEC: assert property ((elec_uv_i || elec_ov_i) [*4] |->
		diag_byte_o[DG_ELEC_BIT])
		else $error("electronics supply fault not flagged");
	AST_SENS: assert property ((sens_uv_i || sens_ov_i) [*4] |->
		diag_byte_o[DG_SENS_BIT])
		else $error("sensor supply fault not flagged");
	AST_COMM_CLR: assert property (link_cycle_i && cfg_valid_o |->
		##[1:3] !comm_lamp_o)
		else $error("link lamp stays lit with traffic");
	AST_COMM_SET: assert property (quiet_reg > COMM_TIMEOUT + 3 |->
		comm_lamp_o && diag_byte_o[DG_COMM_BIT])
		else $error("silent link not flagged");
	AST_TX_HOLD: assert property (tx_valid_o && !tx_ready_i |=>
		tx_valid_o && $stable(tx_byte_o))
		else $error("byte dropped during stall");
	AST_LAMPS: assert property (cfg_valid_o && $past(cfg_valid_o) |->
		chan_lamp_o == {input_image_o[15:8] & {8{two_byte_o}},
		input_image_o[7:0]})
		else $error("channel lamps differ from inputs");
	AST_OVL: assert property (sens_overload_i [*3] |-> !sens_supply_en_o)
		else $error("sensor supply kept on in overload");
endmodule : dln_node_chk
